// [sadr_alarm_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none

module sadr_alarm_ctrl
  import sadr_pkg::*;
#(
  parameter int BLINK_CYCLES = BLINK_CYC,
  parameter int HALF_CYCLES  = HALF_CYC
)(
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  input  wire logic [NUM_ALARMS-1:0]  alarm_detect,
  input  wire logic [CTRL_WORD_W-1:0] ctrl_word,
  input  wire logic                   tool_reset_req,
  output logic      [13:0]            seg_out,
  output logic                        alarm_active,
  output logic      [NUM_ALARMS-1:0]  alarm_latched
);

  logic [NUM_ALARMS-1:0] latch_q, latch_d;
  logic                  fr_prev_q, fr_prev_d;
  logic [31:0]           blink_cnt_q, blink_cnt_d;
  logic                  lit_q, lit_d;
  logic [31:0]           half_cnt_q, half_cnt_d;
  logic                  half_sel_q, half_sel_d;
  logic [13:0]           seg_q, seg_d;
  logic [4:0]            top_idx;
  logic [13:0]           first_half;
  logic [13:0]           second_half;
  logic                  four_char;
  logic                  clear_req;
  logic                  fault_bit;

  // Power-up and sys_rst are the same event here, so reset empties the latch.
  assign fault_bit = ctrl_word[FAULT_RESET_BIT];
  assign clear_req = (fault_bit && !fr_prev_q) || tool_reset_req;

  // A new detection wins over a clear in the same cycle, so no alarm is lost.
  always_comb begin
    latch_d   = latch_q | alarm_detect;
    if (clear_req) begin
      latch_d = (latch_q & ~RESETTABLE_MASK) | alarm_detect;
    end
    fr_prev_d = fault_bit;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      latch_q   <= '0;
      fr_prev_q <= 1'b1;
    end else begin
      latch_q   <= latch_d;
      fr_prev_q <= fr_prev_d;
    end
  end

  // Priority pick: lowest index wins, scanned from the top down.
  always_comb begin
    top_idx = 5'h00;
    for (int i = NUM_ALARMS - 1; i >= 0; i--) begin
      if (latch_q[i]) begin
        top_idx = 5'(i);
      end
    end
  end

  sadr_code_rom u_rom (
    .idx         (top_idx),
    .first_half  (first_half),
    .second_half (second_half),
    .four_char   (four_char)
  );

  // Blink and half timers restart when no alarm is latched, so an alarm that
  // arrives at an empty latch begins lit and on its first half.
  always_comb begin
    blink_cnt_d = blink_cnt_q;
    lit_d       = lit_q;
    half_cnt_d  = half_cnt_q;
    half_sel_d  = half_sel_q;
    if (latch_q == '0) begin
      blink_cnt_d = '0;
      lit_d       = 1'b1;
      half_cnt_d  = '0;
      half_sel_d  = 1'b0;
    end else begin
      if (blink_cnt_q == 32'(BLINK_CYCLES - 1)) begin
        blink_cnt_d = '0;
        lit_d       = !lit_q;
      end else begin
        blink_cnt_d = blink_cnt_q + 32'h1;
      end
      if (!four_char) begin
        half_cnt_d = '0;
        half_sel_d = 1'b0;
      end else if (half_cnt_q == 32'(HALF_CYCLES - 1)) begin
        half_cnt_d = '0;
        half_sel_d = !half_sel_q;
      end else begin
        half_cnt_d = half_cnt_q + 32'h1;
      end
    end
  end

  // Display data is registered so the segment pins never glitch.
  always_comb begin
    if (latch_q == '0) begin
      seg_d = {SEG_BLANK, SEG_BLANK};
    end else if (!lit_q) begin
      seg_d = {SEG_BLANK, SEG_BLANK};
    end else if (half_sel_q) begin
      seg_d = second_half;
    end else begin
      seg_d = first_half;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      blink_cnt_q <= '0;
      lit_q       <= 1'b1;
      half_cnt_q  <= '0;
      half_sel_q  <= 1'b0;
      seg_q       <= '0;
    end else begin
      blink_cnt_q <= blink_cnt_d;
      lit_q       <= lit_d;
      half_cnt_q  <= half_cnt_d;
      half_sel_q  <= half_sel_d;
      seg_q       <= seg_d;
    end
  end

  assign seg_out       = seg_q;
  assign alarm_active  = |latch_q;
  assign alarm_latched = latch_q;

  // A latched alarm stays set while no clear is requested.
  hold_latch_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !clear_req |=> (latch_q & $past(latch_q)) == $past(latch_q))
    else $error("latched alarm dropped without a clear");

  // Rising bit 7 clears resettable bits not redetected.
  fault_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (fault_bit && !fr_prev_q) |=> ((latch_q & RESETTABLE_MASK)
      == ($past(alarm_detect) & RESETTABLE_MASK)))
    else $error("fault reset did not clear resettable alarms");

  // A tool reset clears resettable bits too.
  tool_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
    tool_reset_req |=> ((latch_q & RESETTABLE_MASK)
      == ($past(alarm_detect) & RESETTABLE_MASK)))
    else $error("tool reset did not clear resettable alarms");

  // Major alarms survive any reset request.
  major_keep_a: assert property (@(posedge mclk) disable iff (sys_rst)
    clear_req |=> ((latch_q & ~RESETTABLE_MASK)
      & $past(latch_q & ~RESETTABLE_MASK)) == $past(latch_q & ~RESETTABLE_MASK))
    else $error("non-resettable alarm was cleared");

  // Holding bit 7 high does not clear a second time.
  level_noclear_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (fault_bit && fr_prev_q && !tool_reset_req) |=>
      (latch_q & $past(latch_q)) == $past(latch_q))
    else $error("held fault bit cleared again");

  // The latch is empty right after reset.
  reset_empty_a: assert property (@(posedge mclk)
    $fell(sys_rst) |-> latch_q == '0)
    else $error("alarm survived reset");

  // Non-resettable mask itself: reset never clears index 5.
  enc_keep_a: assert property (@(posedge mclk) disable iff (sys_rst)
    latch_q[5] |=> latch_q[5])
    else $error("encoder error cleared by reset");

  // Display goes dark in the cycle after lit falls while an alarm stays.
  sequence dark_phase_s;
    !lit_q && alarm_active;
  endsequence
  blink_dark_a: assert property (@(posedge mclk) disable iff (sys_rst)
    dark_phase_s |=> seg_q == '0)
    else $error("display lit during dark blink phase");

  // The lit first half shows the top alarm's code one cycle later.
  show_code_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (alarm_active && lit_q && !half_sel_q) |=> seg_q == $past(first_half))
    else $error("displayed code mismatch");

  // Two-character codes never show the second half.
  two_char_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (alarm_active && !four_char) |=> !half_sel_q)
    else $error("second half shown for short code");

  // A detection in the same cycle as a clear is still latched.
  set_wins_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (|alarm_detect) |=> (latch_q & $past(alarm_detect)) == $past(alarm_detect))
    else $error("new alarm lost to a clear");

  // Lit and dark phases each last the full blink count, no more and no less.
  blink_toggle_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (alarm_active && blink_cnt_q == 32'(BLINK_CYCLES - 1)) |=> lit_q != $past(lit_q))
    else $error("blink phase did not toggle at its end");
  blink_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (alarm_active && blink_cnt_q != 32'(BLINK_CYCLES - 1)) |=> lit_q == $past(lit_q))
    else $error("blink phase toggled early");

  // A four-character code swaps halves when its half period ends.
  sequence half_end_s;
    alarm_active && four_char && half_cnt_q == 32'(HALF_CYCLES - 1);
  endsequence
  half_swap_a: assert property (@(posedge mclk) disable iff (sys_rst)
    half_end_s |=> half_sel_q != $past(half_sel_q))
    else $error("code halves did not swap");

endmodule

`default_nettype wire

// [sadr_code_rom.sv]
`timescale 1ns/1ps
`default_nettype none

// Code table: two halves of the display code of alarms 0 to 29, and its length; alarm 30 falls to the blank default.
module sadr_code_rom
  import sadr_pkg::*;
(
  input  wire logic [4:0]  idx,
  output logic      [13:0] first_half,
  output logic      [13:0] second_half,
  output logic             four_char
);

  // Entries follow the display priority order; unused halves are blank.
  always_comb begin
    first_half  = {SEG_BLANK, SEG_BLANK};
    second_half = {SEG_BLANK, SEG_BLANK};
    four_char   = 1'b0;
    unique case (idx)
      5'h00: first_half = {SEG_O, SEG_C};
      5'h01: begin first_half = {SEG_O, SEG_C}; second_half = {SEG_0, SEG_2}; four_char = 1'b1; end
      5'h02: first_half = {SEG_O, SEG_S};
      5'h03: begin first_half = {SEG_L, SEG_U}; second_half = {SEG_C, SEG_O}; four_char = 1'b1; end
      5'h04: first_half = {SEG_H, SEG_U};
      5'h05: first_half = {SEG_E, SEG_1};
      5'h06: begin first_half = {SEG_E, SEG_1}; second_half = {SEG_0, SEG_2}; four_char = 1'b1; end
      5'h07: first_half = {SEG_D, SEG_E};
      5'h08: first_half = {SEG_C, SEG_E};
      5'h09: first_half = {SEG_E, SEG_C};
      5'h0A: first_half = {SEG_C, SEG_O};
      5'h0B: first_half = {SEG_O, SEG_L};
      5'h0C: begin first_half = {SEG_O, SEG_L}; second_half = {SEG_0, SEG_2}; four_char = 1'b1; end
      5'h0D: begin first_half = {SEG_R, SEG_H}; second_half = {SEG_0, SEG_4}; four_char = 1'b1; end
      5'h0E: begin first_half = {SEG_S, SEG_F}; second_half = {SEG_E, SEG_R}; four_char = 1'b1; end
      5'h0F: begin first_half = {SEG_L, SEG_U}; second_half = {SEG_P, SEG_O}; four_char = 1'b1; end
      5'h10: first_half = {SEG_R, SEG_H};
      5'h11: begin first_half = {SEG_R, SEG_H}; second_half = {SEG_0, SEG_2}; four_char = 1'b1; end
      5'h12: begin first_half = {SEG_R, SEG_H}; second_half = {SEG_0, SEG_3}; four_char = 1'b1; end
      5'h13: first_half = {SEG_O, SEG_F};
      5'h14: first_half = {SEG_A, SEG_H};
      5'h15: first_half = {SEG_E, SEG_H};
      5'h16: first_half = {SEG_D, SEG_L};
      5'h17: begin first_half = {SEG_D, SEG_L}; second_half = {SEG_0, SEG_2}; four_char = 1'b1; end
      5'h18: begin first_half = {SEG_D, SEG_L}; second_half = {SEG_0, SEG_3}; four_char = 1'b1; end
      5'h19: first_half = {SEG_A, SEG_F};
      5'h1A: first_half = {SEG_I, SEG_E};
      5'h1B: first_half = {SEG_H, SEG_F};
      5'h1C: begin first_half = {SEG_O, SEG_L}; second_half = {SEG_0, SEG_3}; four_char = 1'b1; end
      5'h1D: first_half = {SEG_C, SEG_E};
      default: first_half = {SEG_BLANK, SEG_BLANK};
    endcase
  end

endmodule

`default_nettype wire

// [sadr_master_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Fieldbus master: holds an operating state and pulses the fault reset bit on request.
module sadr_master_model
  import sadr_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   fr_cmd,
  output logic      [CTRL_WORD_W-1:0] ctrl_word
);
  logic [1:0] hold_q;

  // Power up in an operating state with the reset bit low.
  initial begin
    ctrl_word = 16'h000F;
    hold_q    = 2'h0;
  end

  // Bit 7 stays up two cycles and is back low before any other state is sent.
  always @(posedge mclk) begin
    if (fr_cmd) begin
      ctrl_word[FAULT_RESET_BIT] <= 1'b1;
      hold_q                     <= 2'h2;
    end else if (hold_q != 2'h0) begin
      hold_q                     <= hold_q - 2'h1;
      ctrl_word[FAULT_RESET_BIT] <= (hold_q != 2'h1);
    end
  end
endmodule

`default_nettype wire

// [sadr_pkg.sv]
package sadr_pkg;

  // Number of alarm sources, in display priority order (index 0 wins).
  localparam int NUM_ALARMS = 31;

  // Clock rate and display timing.
  localparam int CLK_HZ       = 125_000_000;
  localparam int BLINK_MS     = 500;
  localparam int HALF_SHOW_MS = 2000;
  localparam int BLINK_CYC    = CLK_HZ / 1000 * BLINK_MS;
  localparam int HALF_CYC     = CLK_HZ / 1000 * HALF_SHOW_MS;

  // Bit of the received control word that requests a fault reset.
  localparam int FAULT_RESET_BIT = 7;
  localparam int CTRL_WORD_W     = 16;

  // Seven-segment glyphs, bit 0 = segment a ... bit 6 = segment g.
  localparam logic [6:0] SEG_O = 7'h5C;
  localparam logic [6:0] SEG_C = 7'h58;
  localparam logic [6:0] SEG_S = 7'h6D;
  localparam logic [6:0] SEG_L = 7'h38;
  localparam logic [6:0] SEG_U = 7'h1C;
  localparam logic [6:0] SEG_H = 7'h76;
  localparam logic [6:0] SEG_E = 7'h79;
  localparam logic [6:0] SEG_D = 7'h5E;
  localparam logic [6:0] SEG_R = 7'h50;
  localparam logic [6:0] SEG_A = 7'h77;
  localparam logic [6:0] SEG_F = 7'h71;
  localparam logic [6:0] SEG_P = 7'h73;
  localparam logic [6:0] SEG_I = 7'h10;
  localparam logic [6:0] SEG_0 = 7'h3F;
  localparam logic [6:0] SEG_1 = 7'h06;
  localparam logic [6:0] SEG_2 = 7'h5B;
  localparam logic [6:0] SEG_3 = 7'h4F;
  localparam logic [6:0] SEG_4 = 7'h66;
  localparam logic [6:0] SEG_BLANK = 7'h00;

  // Alarm index map: {resettable mask} bit set means a reset may clear it.
  localparam logic [NUM_ALARMS-1:0] RESETTABLE_MASK = 31'h783B9A1F;

endpackage

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none

module tb;
  import sadr_pkg::*;
  localparam int          BLK    = 4;
  localparam int          HLF    = 16;
  // Row table: bit i set means alarm i must clear on a reset request.
  localparam logic [30:0] CLEARS = 31'h783B9A1F;

  logic                   mclk           = 1'b0;
  logic                   sys_rst        = 1'b1;
  logic [NUM_ALARMS-1:0]  alarm_detect   = '0;
  logic                   tool_reset_req = 1'b0;
  logic                   fr_cmd         = 1'b0;
  logic [CTRL_WORD_W-1:0] ctrl_word;
  logic [13:0]            seg_out;
  logic [13:0]            s0;
  logic [13:0]            s1;
  logic                   alarm_active;
  logic [NUM_ALARMS-1:0]  alarm_latched;
  int                     err_count      = 0;
  int                     tests_run      = 0;
  int                     cycles         = 0;
  int                     dark;

  // Short counts keep the blink and half-swap visible in a short run.
  sadr_alarm_ctrl #(.BLINK_CYCLES(BLK), .HALF_CYCLES(HLF)) i_dut (
    .mclk          (mclk),
    .sys_rst       (sys_rst),
    .alarm_detect  (alarm_detect),
    .ctrl_word     (ctrl_word),
    .tool_reset_req(tool_reset_req),
    .seg_out       (seg_out),
    .alarm_active  (alarm_active),
    .alarm_latched (alarm_latched)
  );

  sadr_master_model i_master (
    .mclk     (mclk),
    .fr_cmd   (fr_cmd),
    .ctrl_word(ctrl_word)
  );

  // Free-running clock, 8 ns period.
  always #4 mclk = ~mclk;

  task automatic note(input logic [30:0] got, input logic [30:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_latch(input logic [30:0] g, input logic [30:0] e);
    note(g, e);
  endtask
  task automatic chk_seg(input logic [13:0] g, input logic [13:0] e);
    note({17'h0, g}, {17'h0, e});
  endtask
  task automatic chk_flag(input logic g, input logic e);
    note({30'h0, g}, {30'h0, e});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // A power cycle must leave nothing latched, whatever the alarm class.
  task automatic pwr();
    sys_rst = 1'b1;
    cyc(2);
    sys_rst = 1'b0;
    chk_latch(alarm_latched, 31'h0);
  endtask

  // Pulse one alarm's detector for a single cycle.
  task automatic hit(input int i);
    alarm_detect[i] = 1'b1;
    cyc(1);
    alarm_detect = '0;
    cyc(1);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // A hung design still reaches the report.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      results();
    end
  end

  // Odd rows clear through the host tool, even rows through the control word.
  initial begin
    cyc(2);
    sys_rst = 1'b0;
    chk_latch(alarm_latched, 31'h0);
    chk_seg(seg_out, 14'h0);
    for (int i = 0; i < NUM_ALARMS; i++) begin
      hit(i);
      cyc(2);
      chk_latch(alarm_latched, 31'h1 << i);
      chk_flag(alarm_active, 1'b1);
      if (i % 2 == 1) tool_reset_req = 1'b1;
      else fr_cmd = 1'b1;
      cyc(1);
      tool_reset_req = 1'b0;
      fr_cmd = 1'b0;
      cyc(4);
      chk_latch(alarm_latched, CLEARS[i] ? 31'h0 : 31'h1 << i);
      chk_flag(alarm_active, !CLEARS[i]);
      pwr();
    end
    // Two alarms at once: the earlier listed one is shown, then it blinks evenly.
    alarm_detect[5] = 1'b1;
    hit(2);
    chk_seg(seg_out, {SEG_O, SEG_S});
    dark = 0;
    repeat (8 * BLK) begin
      cyc(1);
      if (seg_out === 14'h0) dark++;
    end
    note(31'(dark), 31'(4 * BLK));
    pwr();
    // A four-character code swaps halves after the half period and repeats.
    hit(1);
    s0 = seg_out;
    cyc(HLF);
    s1 = seg_out;
    cyc(HLF);
    chk_flag(s0 !== s1 && s0 !== 14'h0, 1'b1);
    chk_seg(seg_out, s0);
    chk_seg(s0, {SEG_O, SEG_C});
    chk_seg(s1, {SEG_0, SEG_2});
    pwr();
    // A detection that lands in the cycle of a clear must survive it.
    alarm_detect[0] = 1'b1;
    tool_reset_req  = 1'b1;
    cyc(1);
    alarm_detect    = '0;
    tool_reset_req  = 1'b0;
    cyc(1);
    chk_latch(alarm_latched, 31'h1);
    pwr();
    results();
  end
endmodule

`default_nettype wire
